// ==== dcc_top.sv ====
// Dual comparator control: control registers, result sync, change flags.
// Assumes an APB master on clk and analog comparators whose raw results
// arrive asynchronously on comp_raw.
//
// Overview of operation
// - Each comparator is powered only while its enable bit is 1.
// - Positive select 0 picks input a, 1 picks input b.
// - Negative select 0 picks the external reference pin, 1 the internal one.
// - With output enable and comparator enable set, the raw result drives the pin.
// - The readable result bit is the result synchronised to clk.
// - The synchronised result reads 0 while the comparator is disabled.
// - Any change of the synchronised result while enabled sets the change flag.
// - A set change flag raises the interrupt request when its mask bit is 1.
// - The flag holds until software clears it and is forced clear while disabled.
// - A second, independent channel has the same layout and behaviour.
`timescale 1ns/10ps

// -------------------------------------------------------------------
// One comparator channel
// -------------------------------------------------------------------
module dcc_chan
	import dcc_pkg::*;
(
	input  wire logic      clk,      // Cpu clock
	input  wire logic      rstn,     // Async reset, low
	input  wire logic      wr_ctrl,  // Control write pulse
	input  wire logic [7:0] wdata,   // Control write data
	input  wire logic      clr_flag, // Flag clear pulse
	input  wire logic      comp_raw, // Raw analog result
	output dcc_ctrl_s      ctrl,     // Stored control bits
	output logic           co,       // Synced result
	output logic           flag,     // Change flag
	output dcc_ana_s       ana,      // Analog controls
	output logic           pin_out   // Output pin data
);

	dcc_ctrl_s ctrl_q;
	dcc_ana_s  ana_q;
	logic      s1_q;
	logic      s2_q;
	logic      co_q;
	logic      co_d;
	logic      flag_q;
	logic      change;

	// Control bits from software
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_S_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= '{ce: wdata[CE_BIT], cp: wdata[CP_BIT],
			            cn: wdata[CN_BIT], oe: wdata[OE_BIT]};
		end
	end

	// Analog controls, registered so pins see clean levels
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ana_q <= ANA_S_RST;
		end else begin
			ana_q.power_on    <= ctrl_q.ce;
			ana_q.pos_sel_b   <= ctrl_q.cp;
			ana_q.neg_sel_int <= ctrl_q.cn;
			ana_q.pin_oe      <= ctrl_q.oe & ctrl_q.ce;
		end
	end

	// Raw result to the pin, deliberately unsynchronised
	// raw result on pin
	assign pin_out = comp_raw & ana_q.pin_oe;

	// Two-stage synchroniser; first stage feeds only the second
	// two flop synchroniser
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= comp_raw;
			s2_q <= s1_q;
		end
	end

	assign co_d = ctrl_q.ce & s2_q;

	// Readable result
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			co_q <= 1'b0;
		end else begin
			co_q <= co_d;
		end
	end

	assign change = ctrl_q.ce & (co_d != co_q);

	// Change flag; disable beats all, then set beats clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag_q <= 1'b0;
		end else if (!ctrl_q.ce) begin
			flag_q <= 1'b0;
		end else if (change) begin
			flag_q <= 1'b1;
		end else if (clr_flag) begin
			flag_q <= 1'b0;
		end
	end

	assign ctrl = ctrl_q;
	assign co   = co_q;
	assign flag = flag_q;
	assign ana  = ana_q;

endmodule // dcc_chan

// -------------------------------------------------------------------
// Top level with APB slave and interrupt
// -------------------------------------------------------------------
module dcc_top
	import dcc_pkg::*;
#(
	parameter int PADDR_W = ADDR_W // Bus address width
)
(
	input  wire logic                clk,      // Cpu clock, 125 MHz
	input  wire logic                rstn,     // Async reset, low
	input  wire logic                psel,     // APB select
	input  wire logic                penable,  // APB enable
	input  wire logic                pwrite,   // APB direction
	input  wire logic [PADDR_W-1:0]  paddr,    // APB byte address
	input  wire logic [DATA_W-1:0]   pwdata,   // APB write data
	input  wire logic [3:0]          pstrb,    // APB byte strobes
	output logic      [DATA_W-1:0]   prdata,   // APB read data
	output logic                     pready,   // APB ready
	output logic                     pslverr,  // APB error
	input  wire logic [NUM_CH-1:0]   comp_raw, // Raw comparator results
	output dcc_ana_s  [NUM_CH-1:0]   ana,      // Analog controls
	output logic      [NUM_CH-1:0]   pin_out,  // Output pin data
	output logic                     irq       // Interrupt, high
);

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (PADDR_W != ADDR_W) begin : g_bad_addr
		$error("dcc_top: PADDR_W must equal ADDR_W");
	end

	dcc_ctrl_s [NUM_CH-1:0] ctrl;
	logic      [NUM_CH-1:0] co;
	logic      [NUM_CH-1:0] flag;
	logic      [NUM_CH-1:0] wr_ctrl;
	logic      [NUM_CH-1:0] clr_flag;
	logic      [NUM_CH-1:0] mask_q;
	logic      [DATA_W-1:0] prdata_q;
	logic      [DATA_W-1:0] rd_d;
	logic                   pready_q;
	logic                   pslverr_q;
	logic                   irq_q;
	logic                   access;
	logic                   commit;
	logic                   wr_en;
	logic                   hit;
	logic      [7:0]        ctrl_wdata;

	// ---------------------------------------------------------------
	// Bus handshake
	// ---------------------------------------------------------------

	// One wait state: ready comes in the second access cycle
	assign access = psel & penable & ~pready_q;
	assign commit = psel & penable & pready_q;
	assign wr_en  = commit & pwrite & pstrb[0];

	// Decode of mapped words
	always_comb begin
		hit = 1'b1;
		case (paddr)
			COMPARATOR_ONE_CONTROL_ADDR, COMPARATOR_TWO_CONTROL_ADDR, STAT_ADDR, MASK_ADDR: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_d = RD_RST;
		case (paddr)
			COMPARATOR_ONE_CONTROL_ADDR: begin
				rd_d[CE_BIT]  = ctrl[0].ce;
				rd_d[CP_BIT]  = ctrl[0].cp;
				rd_d[CN_BIT]  = ctrl[0].cn;
				rd_d[OE_BIT]  = ctrl[0].oe;
				rd_d[CO_BIT]  = co[0];
				rd_d[CMF_BIT] = flag[0];
			end
			COMPARATOR_TWO_CONTROL_ADDR: begin
				rd_d[CE_BIT]  = ctrl[1].ce;
				rd_d[CP_BIT]  = ctrl[1].cp;
				rd_d[CN_BIT]  = ctrl[1].cn;
				rd_d[OE_BIT]  = ctrl[1].oe;
				rd_d[CO_BIT]  = co[1];
				rd_d[CMF_BIT] = flag[1];
			end
			STAT_ADDR: rd_d[NUM_CH-1:0] = flag;
			MASK_ADDR: rd_d[NUM_CH-1:0] = mask_q;
			default:   rd_d = RD_RST;
		endcase
	end

	// Ready, error and read data all from flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= RD_RST;
		end else if (access) begin
			pready_q  <= 1'b1;
			pslverr_q <= ~hit;
			prdata_q  <= (pwrite | ~hit) ? RD_RST : rd_d;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Write strobes to the channels
	// ---------------------------------------------------------------

	// Control word: writing 0 to the flag bit clears it, 1 leaves it alone; status word: writing 1 clears
	assign ctrl_wdata  = pwdata[7:0];
	assign wr_ctrl[0]  = wr_en & (paddr == COMPARATOR_ONE_CONTROL_ADDR);
	assign wr_ctrl[1]  = wr_en & (paddr == COMPARATOR_TWO_CONTROL_ADDR);
	assign clr_flag[0] = (wr_ctrl[0] & ~ctrl_wdata[CMF_BIT])
	                   | (wr_en & (paddr == STAT_ADDR) & pwdata[0]);
	assign clr_flag[1] = (wr_ctrl[1] & ~ctrl_wdata[CMF_BIT])
	                   | (wr_en & (paddr == STAT_ADDR) & pwdata[1]);

	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		dcc_chan u_chan (
			.clk      (clk),
			.rstn     (rstn),
			.wr_ctrl  (wr_ctrl[i]),
			.wdata    (ctrl_wdata),
			.clr_flag (clr_flag[i]),
			.comp_raw (comp_raw[i]),
			.ctrl     (ctrl[i]),
			.co       (co[i]),
			.flag     (flag[i]),
			.ana      (ana[i]),
			.pin_out  (pin_out[i])
		);
	end

	// ---------------------------------------------------------------
	// Interrupt
	// ---------------------------------------------------------------

	// Mask register, 1 lets the flag through
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask_q <= MASK_RST;
		end else if (wr_en && (paddr == MASK_ADDR)) begin
			mask_q <= pwdata[NUM_CH-1:0];
		end
	end

	// Level request, one cycle behind the flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flag & mask_q);
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;

endmodule // dcc_top

// ==== dcc_pkg.sv ====
// Shared constants and carrier types for the dual comparator control block.
// Assumes a 32-bit APB register bus and two analog comparators outside.
package dcc_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int NUM_CH = 2;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ---------------------------------------------------------------
	// Register map (printed offsets are indices, byte address = 4 x index)
	// ---------------------------------------------------------------
	localparam logic [7:0]        COMPARATOR_ONE_CONTROL_IDX  = 8'hac;
	localparam logic [7:0]        COMPARATOR_TWO_CONTROL_IDX  = 8'had;
	localparam logic [ADDR_W-1:0] COMPARATOR_ONE_CONTROL_ADDR = ADDR_W'({COMPARATOR_ONE_CONTROL_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] COMPARATOR_TWO_CONTROL_ADDR = ADDR_W'({COMPARATOR_TWO_CONTROL_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h2c0;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h2c4;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int CE_BIT  = 5;
	localparam int CP_BIT  = 4;
	localparam int CN_BIT  = 3;
	localparam int OE_BIT  = 2;
	localparam int CO_BIT  = 1;
	localparam int CMF_BIT = 0;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]        CTRL_RST = 8'h00;
	localparam logic [NUM_CH-1:0] MASK_RST = 2'h0;
	localparam logic [DATA_W-1:0] RD_RST   = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic ce;  // Comparator enable
		logic cp;  // Positive input select
		logic cn;  // Negative input select
		logic oe;  // Pin output enable
	} dcc_ctrl_s;

	typedef struct packed {
		logic power_on;    // Comparator powered
		logic pos_sel_b;   // 1: input b on positive side
		logic neg_sel_int; // 1: internal reference on negative side
		logic pin_oe;      // Output pin driven
	} dcc_ana_s;

	localparam dcc_ctrl_s CTRL_S_RST = '{ce: 1'b0, cp: 1'b0, cn: 1'b0, oe: 1'b0};
	localparam dcc_ana_s  ANA_S_RST  = '{power_on: 1'b0, pos_sel_b: 1'b0, neg_sel_int: 1'b0, pin_oe: 1'b0};

endpackage

// ==== dcc_assertions.sv ====
// Port checker for the dual comparator control block.
// Assumes it is bound to every dcc_top instance.
`timescale 1ns/10ps
module dcc_assertions
	import dcc_pkg::*;
#(
	parameter int PADDR_W = ADDR_W // Bus address width
)
(
	input wire logic               clk,      // Cpu clock
	input wire logic               rstn,     // Async reset, low
	input wire logic               psel,     // APB select
	input wire logic               penable,  // APB enable
	input wire logic               pwrite,   // APB direction
	input wire logic [PADDR_W-1:0] paddr,    // APB address
	input wire logic [DATA_W-1:0]  prdata,   // APB read data
	input wire logic               pready,   // APB ready
	input wire logic               pslverr,  // APB error
	input wire logic [NUM_CH-1:0]  comp_raw, // Raw results
	input wire dcc_ana_s [NUM_CH-1:0] ana,   // Analog controls
	input wire logic [NUM_CH-1:0]  pin_out,  // Pin data
	input wire logic               irq       // Interrupt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// -----------------------------------------------------------
	// Decode seen by the bus
	// -----------------------------------------------------------
	logic mapped;
	assign mapped = paddr inside {COMPARATOR_ONE_CONTROL_ADDR, COMPARATOR_TWO_CONTROL_ADDR, STAT_ADDR, MASK_ADDR};

	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("ready not in second access cycle");
	err_unmapped_a: assert property (pready |-> (pslverr == !mapped) && (!pslverr || prdata == '0))
		else $error("error response does not match decode");
	pin_drive_a: assert property (pin_out == (comp_raw & {ana[1].pin_oe, ana[0].pin_oe}))
		else $error("pin does not follow raw result");
	oe_power_a: assert property (({ana[1].pin_oe, ana[0].pin_oe} & ~{ana[1].power_on, ana[0].power_on}) == 2'b00)
		else $error("pin driven while comparator off");
	irq_off_a: assert property ((!ana[0].power_on && !ana[1].power_on) [*2] |=> !irq)
		else $error("interrupt with both comparators off");
	ana_commit_a: assert property ($changed(ana) |-> $past(pready && pwrite, 2))
		else $error("analog controls moved without a write");
	co_off_read_a: assert property (pready && !pwrite && paddr == COMPARATOR_ONE_CONTROL_ADDR && !ana[0].power_on
		&& !$past(ana[0].power_on) && !$past(ana[0].power_on, 2) |-> prdata[1:0] == 2'b00)
		else $error("result or flag nonzero while off");
	flag_irq_a: assert property (irq |-> ana[0].power_on || ana[1].power_on || $past(ana[0].power_on || ana[1].power_on))
		else $error("interrupt without a live channel");

	irq_seen_c: cover property ($rose(irq));
	err_seen_c: cover property (pready && pslverr);
	pin_two_c: cover property (pin_out[1]);
endmodule // dcc_assertions

bind dcc_top dcc_assertions #(.PADDR_W(PADDR_W)) u_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .comp_raw, .ana, .pin_out, .irq);

// ==== dcc_comp_model.sv ====
// Behavioural pair of analog comparators behind the control block.
// Assumes the bench gives input voltages as logic levels.
`timescale 1ns/10ps
module dcc_comp_model
	import dcc_pkg::*;
(
	input wire dcc_ana_s [NUM_CH-1:0] ana,     // Analog controls
	input wire logic [NUM_CH-1:0]     in_a,    // Candidate input a
	input wire logic [NUM_CH-1:0]     in_b,    // Candidate input b
	input wire logic [NUM_CH-1:0]     ext_ref, // External reference pin
	input wire logic [NUM_CH-1:0]     int_ref, // Internal reference
	output logic     [NUM_CH-1:0]     comp_raw // Raw results
);
	// Unpowered parts float high, so masking in the block is really tested
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			comp_raw[i] = !ana[i].power_on | ((ana[i].pos_sel_b ? in_b[i] : in_a[i])
				& ~(ana[i].neg_sel_int ? int_ref[i] : ext_ref[i]));
		end
	end
endmodule // dcc_comp_model

// ==== dcc_top_tb.sv ====
// Self-checking bench for the dual comparator control block.
// Assumes the comparator model and the checker are compiled first.
`timescale 1ns/10ps
module dcc_top_tb
	import dcc_pkg::*;
;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = '0;
	logic [NUM_CH-1:0] comp_raw, pin_out, lv_a = '0, lv_b = '0, lv_e = '0, lv_i = '0;
	dcc_ana_s [NUM_CH-1:0] ana;
	int err_count = 0, samples_checked = 0;

	always #4 clk = ~clk;

	dcc_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .comp_raw, .ana, .pin_out, .irq);
	dcc_comp_model u_cmp (.ana, .in_a(lv_a), .in_b(lv_b), .ext_ref(lv_e), .int_ref(lv_i), .comp_raw);

	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, msg, seen, exp);
		end
	endtask

	// One APB transfer; a spare edge first keeps back-to-back drives apart
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_count++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'h1);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, '0, 4'h0);
		chk(rd, exp, msg);
	endtask

	// Result path is three edges plus one for the analog controls
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask

	// -----------------------------------------------------------
	// Sequence
	// -----------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0, "ctrl1 reset");
		rdc(COMPARATOR_TWO_CONTROL_ADDR, 32'h0, "ctrl2 reset");
		rdc(MASK_ADDR, 32'h0, "mask reset");
		rdc(12'h100, 32'h0, "unmapped data");
		chk(32'(er), 32'h1, "unmapped error");
		lv_a <= 2'b11;
		lv_i <= 2'b11;
		wr(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0025);
		repeat (1250) @(posedge clk);
		chk(32'(ana[0]), 32'h9, "ch1 analog");
		chk(32'(pin_out), 32'h1, "ch1 pin");
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0027, "ch1 on");
		rdc(COMPARATOR_TWO_CONTROL_ADDR, 32'h0, "ch2 untouched");
		chk(32'(irq), 32'h0, "masked irq");
		for (int k = 0; k < 4; k++) begin
			wr(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0025 | (32'(k) << 3));
			settle();
			apb(1'b0, COMPARATOR_ONE_CONTROL_ADDR, '0, 4'h0);
			chk(32'(rd[1]), 32'(k == 0), "routing");
		end
		wr(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0025);
		settle();
		rdc(STAT_ADDR, 32'h1, "flag set");
		wr(MASK_ADDR, 32'h3);
		settle();
		chk(32'(irq), 32'h1, "irq up");
		wr(STAT_ADDR, 32'h1);
		settle();
		chk(32'(irq), 32'h0, "irq cleared");
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0026, "flag cleared");
		lv_a <= 2'b10;
		settle();
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0025, "fall sets flag");
		wr(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0024);
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0024, "ctrl clears flag");
		// result change lands on the clearing write
		fork
			wr(STAT_ADDR, 32'h1);
			begin
				@(posedge clk);
				lv_a <= 2'b11;
			end
		join
		settle();
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0000_0027, "set beats clear");
		wr(COMPARATOR_ONE_CONTROL_ADDR, 32'h1);
		settle();
		rdc(COMPARATOR_ONE_CONTROL_ADDR, 32'h0, "off clears");
		chk(32'(pin_out), 32'h0, "pin off");
		lv_b <= 2'b10;
		wr(COMPARATOR_TWO_CONTROL_ADDR, 32'h0000_0035);
		repeat (1250) @(posedge clk);
		apb(1'b1, COMPARATOR_TWO_CONTROL_ADDR, 32'h0, 4'h0);
		rdc(COMPARATOR_TWO_CONTROL_ADDR, 32'h0000_0037, "ch2 on");
		rdc(STAT_ADDR, 32'h2, "ch2 flag only");
		chk(32'(pin_out), 32'h2, "ch2 pin");
		chk(32'(ana[1]), 32'hd, "ch2 analog");
		tally_and_finish();
	end
endmodule // dcc_top_tb
